// >>> vup_uv_pg.sv
//Contract
//RULE_01 - Input UV fault stays active until input rises above the warning threshold.
//RULE_02 - Below warning threshold: set catch-all, input and UV warning status, alert host.
//RULE_03 - Warning threshold defaults to 1.03 times the strapped fault threshold.
//RULE_04 - Both input UV thresholds are two-byte writable protectable Linear-11 volts.
//RULE_05 - Fault threshold resets from the pin strap, not a constant.
//RULE_06 - Fault action is a writable byte resetting to 80h.
//RULE_07 - Action code 10 disables output then retries per bits 5:3; 00, 01 unused. Code retries only for 111; 001-110 latch off like 000.
//RULE_08 - Action code 11 disables output only while the fault persists, then resumes.
//RULE_09 - Any fault response pulls alert low and sets fault bit, cleared by CLEAR_FAULTS.
//RULE_10 - Retry code 000 means no restart until the fault is cleared.
//RULE_11 - Retry code 111 restarts forever until commanded off or another fault.
//RULE_12 - Restart attempts are spaced in units of 70 ms.
//RULE_13 - Action bits 2:0 have no effect.
//RULE_14 - Power good asserts when output exceeds the power-good-on threshold.
//RULE_15 - Power good deasserts only below the output UV fault limit.
//RULE_16 - Host must program power-good-on above the output UV fault limit.
//RULE_17 - Power-good-on is a two-byte writable protectable unsigned Linear-16 value.
//RULE_18 - Power-good-on resets to 0.9 times the strapped output voltage command.
//RULE_19 - Each new measurement updates warning, fault and power-good state that cycle.
`timescale 1ns/1ps

module vup_uv_pg import vup_pkg::*; #(
  parameter int unsigned RETRY_WAIT_CYCLES = RETRY_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_wdata,
  input wire logic write_protect,
  input wire logic [15:0] strap_uv_fault,
  input wire logic [15:0] strap_vout_cmd,
  input wire logic [15:0] vin_meas,
  input wire logic vin_valid,
  input wire logic [15:0] vout_meas,
  input wire logic vout_valid,
  input wire logic [15:0] vout_uv_limit,
  input wire logic on_cmd,
  input wire logic other_fault,
  output logic [15:0] rd_data_q,
  output logic rd_ack_q,
  output logic output_en_q,
  output logic power_good_q,
  output logic alert_line_n_q,
  output logic stat_none_q,
  output logic stat_input_q,
  output logic stat_vin_uv_warn_q,
  output logic stat_vin_uv_fault_q,
  output logic uv_fault_active_q,
  output logic uv_warn_active_q
);

  logic [15:0] warn_thr_q;
  logic [15:0] fault_thr_q;
  logic [7:0] action_q;
  logic [15:0] pg_on_q;
  logic strap_load_q;
  vup_resp_e resp_q;
  vup_resp_e resp_d;
  logic [31:0] retry_cnt_q;

  logic [15:0] warn_default;
  logic [26:0] pg_prod;
  logic signed [FIX_W-1:0] vin_fix;
  logic signed [FIX_W-1:0] warn_fix;
  logic signed [FIX_W-1:0] fault_fix;
  logic vin_below_warn;
  logic vin_below_fault;
  logic vin_above_warn;
  logic fault_active_d;
  logic warn_event;
  logic fault_event;
  logic clear_faults;
  logic wr_ok;
  logic none_d;
  logic input_d;
  logic warn_bit_d;
  logic fault_bit_d;
  logic [1:0] act_mode;
  logic [2:0] act_retry;
  logic retry_done;

  vup_l11_scale u_warn_scale (
    .l11_in(strap_uv_fault),
    .factor(WARN_SCALE),
    .l11_out(warn_default)
  );

  vup_l11_fix u_vin_fix (
    .l11(vin_meas),
    .fix(vin_fix)
  );

  vup_l11_fix u_warn_fix (
    .l11(warn_thr_q),
    .fix(warn_fix)
  );

  vup_l11_fix u_fault_fix (
    .l11(fault_thr_q),
    .fix(fault_fix)
  );

  assign pg_prod = strap_vout_cmd * PG_SCALE;

  // Write protection blocks all setting writes but never CLEAR_FAULTS
  assign wr_ok = cmd_wr && !write_protect;
  assign clear_faults = cmd_wr && (cmd_code == CMD_CLEAR_FAULTS);

  // Straps are sampled on the first edge after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_load_q <= 1'b1;
    end else begin
      strap_load_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_thr_q <= RST_VIN_UV_FAULT;
    end else if (strap_load_q) begin
      fault_thr_q <= strap_uv_fault; // see RULE_05
    end else if (wr_ok && cmd_code == CMD_VIN_UV_FAULT) begin
      fault_thr_q <= cmd_wdata; // see RULE_04
    end
  end

  // Default tracks the strapped fault limit, not a later written one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warn_thr_q <= RST_VIN_UV_WARN;
    end else if (strap_load_q) begin
      warn_thr_q <= warn_default; // see RULE_03
    end else if (wr_ok && cmd_code == CMD_VIN_UV_WARN) begin
      warn_thr_q <= cmd_wdata; // see RULE_04
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      action_q <= RST_VIN_UV_ACTION; // see RULE_06
    end else if (wr_ok && cmd_code == CMD_VIN_UV_ACTION) begin
      action_q <= cmd_wdata[7:0]; // see RULE_06
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pg_on_q <= RST_PG_ON;
    end else if (strap_load_q) begin
      pg_on_q <= pg_prod[SCALE_SHIFT+15:SCALE_SHIFT]; // see RULE_18
    end else if (wr_ok && cmd_code == CMD_PG_ON) begin
      pg_on_q <= cmd_wdata; // see RULE_17
    end
  end

  // Read port: one cycle latency, unmapped codes read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= cmd_rd;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q <= RST_RD_DATA;
    end else if (cmd_rd) begin
      unique case (cmd_code)
        CMD_VIN_UV_WARN: rd_data_q <= warn_thr_q;
        CMD_VIN_UV_FAULT: rd_data_q <= fault_thr_q;
        CMD_VIN_UV_ACTION: rd_data_q <= {8'h00, action_q};
        CMD_PG_ON: rd_data_q <= pg_on_q;
        default: rd_data_q <= RST_RD_DATA;
      endcase
    end
  end

  // Comparisons act only on a fresh sample
  always_comb begin
    vin_below_warn = vin_fix < warn_fix;
    vin_below_fault = vin_fix < fault_fix;
    vin_above_warn = vin_fix > warn_fix;
    warn_event = vin_valid && vin_below_warn; // see RULE_19
    fault_event = vin_valid && vin_below_fault; // see RULE_19
    fault_active_d = uv_fault_active_q;
    if (fault_event) begin
      fault_active_d = 1'b1;
    end else if (vin_valid && vin_above_warn) begin
      fault_active_d = 1'b0; // see RULE_01
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      uv_fault_active_q <= 1'b0;
    end else begin
      uv_fault_active_q <= fault_active_d; // see RULE_01
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      uv_warn_active_q <= 1'b0;
    end else if (vin_valid) begin
      uv_warn_active_q <= vin_below_warn; // see RULE_19
    end
  end

  // Sticky status; a new event in the clearing cycle wins
  always_comb begin
    none_d = stat_none_q;
    input_d = stat_input_q;
    warn_bit_d = stat_vin_uv_warn_q;
    fault_bit_d = stat_vin_uv_fault_q;
    if (clear_faults) begin
      none_d = 1'b0;
      input_d = 1'b0;
      warn_bit_d = 1'b0;
      fault_bit_d = 1'b0; // see RULE_09
    end
    if (warn_event || fault_event) begin
      none_d = 1'b1; // see RULE_02
      input_d = 1'b1; // see RULE_02
    end
    if (warn_event) begin
      warn_bit_d = 1'b1; // see RULE_02
    end
    if (fault_event) begin
      fault_bit_d = 1'b1; // see RULE_09
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_none_q <= 1'b0;
      stat_input_q <= 1'b0;
      stat_vin_uv_warn_q <= 1'b0;
      stat_vin_uv_fault_q <= 1'b0;
    end else begin
      stat_none_q <= none_d;
      stat_input_q <= input_d;
      stat_vin_uv_warn_q <= warn_bit_d;
      stat_vin_uv_fault_q <= fault_bit_d;
    end
  end

  // Alert follows the sticky bits, so it releases only on clearing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alert_line_n_q <= 1'b1;
    end else begin
      alert_line_n_q <= !(none_d || input_d || warn_bit_d || fault_bit_d); // see RULE_02 RULE_09
    end
  end

  // Bits 2:0 are never decoded
  assign act_mode = action_q[ACT_MODE_HI:ACT_MODE_LO]; // see RULE_13
  assign act_retry = action_q[ACT_RETRY_HI:ACT_RETRY_LO];
  assign retry_done = retry_cnt_q >= (RETRY_WAIT_CYCLES - 32'h1);

  // Fault response sequencer
  always_comb begin
    resp_d = resp_q;
    unique case (resp_q)
      VUP_RUN: begin
        if (fault_event && act_mode == MODE_DISABLE_RETRY) begin
          if (act_retry == RETRY_FOREVER) begin
            resp_d = VUP_RETRY_WAIT; // see RULE_07
          end else begin
            // Unused retry codes behave as no retry
            resp_d = VUP_LATCHED_OFF; // see RULE_10
          end
        end else if (fault_event && act_mode == MODE_WHILE_PRESENT) begin
          resp_d = VUP_OFF_WHILE_FAULT; // see RULE_08
        end
      end
      VUP_LATCHED_OFF: begin
        if (clear_faults || !on_cmd) begin
          resp_d = VUP_RUN; // see RULE_10
        end
      end
      VUP_RETRY_WAIT: begin
        if (!on_cmd || other_fault) begin
          resp_d = VUP_LATCHED_OFF; // see RULE_11
        end else if (retry_done) begin
          // Restart without rechecking the input
          resp_d = VUP_RUN; // see RULE_11
        end
      end
      VUP_OFF_WHILE_FAULT: begin
        if (!fault_active_d) begin
          resp_d = VUP_RUN; // see RULE_08
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resp_q <= VUP_RUN;
    end else begin
      resp_q <= resp_d;
    end
  end

  // One interval unit between attempts; bits 2:0 hold no multiplier
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      retry_cnt_q <= 32'h0;
    end else if (resp_q == VUP_RETRY_WAIT && !retry_done) begin
      retry_cnt_q <= retry_cnt_q + 32'h1; // see RULE_12
    end else begin
      retry_cnt_q <= 32'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_en_q <= 1'b0;
    end else begin
      output_en_q <= on_cmd && !other_fault && resp_d == VUP_RUN; // see RULE_07 RULE_08
    end
  end

  // Hysteresis relies on the host keeping the on threshold above the UV limit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_good_q <= 1'b0;
    end else if (vout_valid) begin
      if (vout_meas < vout_uv_limit) begin
        power_good_q <= 1'b0; // see RULE_15 RULE_16
      end else if (vout_meas > pg_on_q) begin
        power_good_q <= 1'b1; // see RULE_14 RULE_19
      end
    end
  end

endmodule

// >>> vup_pkg.sv
package vup_pkg;

  // Command codes of CLEAR_FAULTS and of the settings held here
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_VIN_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_VIN_UV_FAULT = 8'h59;
  localparam logic [7:0] CMD_VIN_UV_ACTION = 8'h5A;
  localparam logic [7:0] CMD_PG_ON = 8'h5E;

  // Reset values; thresholds are overwritten from the straps after reset
  localparam logic [15:0] RST_VIN_UV_WARN = 16'h0000;
  localparam logic [15:0] RST_VIN_UV_FAULT = 16'h0000;
  localparam logic [7:0] RST_VIN_UV_ACTION = 8'h80;
  localparam logic [15:0] RST_PG_ON = 16'h0000;
  localparam logic [15:0] RST_RD_DATA = 16'h0000;

  // Fault action byte layout
  localparam int ACT_MODE_HI = 7;
  localparam int ACT_MODE_LO = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] MODE_WHILE_PRESENT = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Linear-11 layout
  localparam int L11_EXP_HI = 15;
  localparam int L11_EXP_LO = 11;
  localparam int L11_MAN_HI = 10;
  localparam int L11_MAN_LO = 0;
  localparam int FIX_FRAC = 8;
  localparam int FIX_W = 36;

  // Default scale factors, numerator over 1024
  localparam int SCALE_SHIFT = 10;
  localparam logic [10:0] WARN_SCALE = 11'h41F;
  localparam logic [10:0] PG_SCALE = 11'h39A;

  // Retry interval unit
  localparam int CLK_PERIOD_NS = 10;
  localparam int RETRY_UNIT_MS = 70;
  localparam int RETRY_CYCLES = RETRY_UNIT_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    VUP_RUN,
    VUP_LATCHED_OFF,
    VUP_RETRY_WAIT,
    VUP_OFF_WHILE_FAULT
  } vup_resp_e;

endpackage

// >>> vup_l11_fix.sv
`timescale 1ns/1ps

// Linear-11 word to signed fixed point with FIX_FRAC fractional bits
module vup_l11_fix import vup_pkg::*; (
  input wire logic [15:0] l11,
  output logic signed [FIX_W-1:0] fix
);

  logic signed [4:0] exp_n;
  logic signed [FIX_W-1:0] base;

  always_comb begin
    exp_n = l11[L11_EXP_HI:L11_EXP_LO];
    base = FIX_W'(signed'(l11[L11_MAN_HI:L11_MAN_LO])) <<< FIX_FRAC;
    if (exp_n >= 0) begin
      fix = base <<< exp_n;
    end else begin
      fix = base >>> (-exp_n);
    end
  end

endmodule

// >>> vup_l11_scale.sv
`timescale 1ns/1ps

// Scales a Linear-11 value by factor/1024, keeping it in Linear-11 form
module vup_l11_scale import vup_pkg::*; (
  input wire logic [15:0] l11_in,
  input wire logic [10:0] factor,
  output logic [15:0] l11_out
);

  logic signed [22:0] prod;
  logic signed [12:0] scaled;
  logic [4:0] exp_n;

  always_comb begin
    prod = 23'(signed'(l11_in[L11_MAN_HI:L11_MAN_LO])) * signed'({1'b0, factor});
    scaled = prod[SCALE_SHIFT+12:SCALE_SHIFT];
    exp_n = l11_in[L11_EXP_HI:L11_EXP_LO];
    // Mantissa overflow trades one bit of resolution for a larger exponent
    if (scaled[12:10] == 3'h0 || scaled[12:10] == 3'h7) begin
      l11_out = {exp_n, scaled[10:0]};
    end else begin
      l11_out = {5'(exp_n + 5'h01), scaled[11:1]};
    end
  end

endmodule

// >>> vup_host_model.sv
`timescale 1ns/1ps
module vup_host_model (
  input wire logic clk,
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] rd_data_q,
  input wire logic rd_ack_q
);
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // Starts an edge late so a request never drops and rises in one step
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1;
    cmd_code = c;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(posedge clk);
    #1;
    cmd_wr = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    int n;
    @(posedge clk);
    #1;
    cmd_code = c;
    cmd_rd = 1'b1;
    @(posedge clk);
    #1;
    cmd_rd = 1'b0;
    cmd_code = ~c;
    n = 0;
    while (rd_ack_q !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = rd_data_q;
  endtask
endmodule

// >>> vup_uv_pg_chk.sv
`timescale 1ns/1ps
module vup_uv_pg_chk import vup_pkg::*; #(
  parameter int unsigned RETRY_WAIT_CYCLES = RETRY_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_wdata,
  input wire logic write_protect,
  input wire logic [15:0] strap_uv_fault,
  input wire logic [15:0] strap_vout_cmd,
  input wire logic [15:0] vin_meas,
  input wire logic vin_valid,
  input wire logic [15:0] vout_meas,
  input wire logic vout_valid,
  input wire logic [15:0] vout_uv_limit,
  input wire logic on_cmd,
  input wire logic other_fault,
  input wire logic [15:0] rd_data_q,
  input wire logic rd_ack_q,
  input wire logic output_en_q,
  input wire logic power_good_q,
  input wire logic alert_line_n_q,
  input wire logic stat_none_q,
  input wire logic stat_input_q,
  input wire logic stat_vin_uv_warn_q,
  input wire logic stat_vin_uv_fault_q,
  input wire logic uv_fault_active_q,
  input wire logic uv_warn_active_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic clr;
  assign clr = cmd_wr && cmd_code == CMD_CLEAR_FAULTS;
  sequence rd_req; cmd_rd; endsequence
  sequence fault_drop; $fell(uv_fault_active_q); endsequence
  read_answer_a: assert property (rd_req |=> rd_ack_q) else $error("read unanswered");
  ack_pulse_a: assert property (!cmd_rd |=> !rd_ack_q) else $error("stray ack");
  alert_fault_a: assert property (stat_vin_uv_fault_q |-> !alert_line_n_q) else $error("alert high");
  sticky_fault_a: assert property (stat_vin_uv_fault_q && !clr |=> stat_vin_uv_fault_q) else $error("lost");
  warn_summary_a: assert property ($rose(stat_vin_uv_warn_q) |-> stat_none_q && stat_input_q) else $error("summary");
  fault_exit_a: assert property (fault_drop |-> $past(vin_valid)) else $error("fault left early");
  pg_rise_a: assert property ($rose(power_good_q) |-> $past(vout_valid)) else $error("pg rose");
  pg_fall_a: assert property ($fell(power_good_q) |-> $past(vout_valid) && $past(vout_meas) < $past(vout_uv_limit))
    else $error("pg fell");
  warn_sample_a: assert property ($changed(uv_warn_active_q) |-> $past(vin_valid)) else $error("warn moved");
  shut_other_a: assert property (other_fault || !on_cmd |=> !output_en_q) else $error("output on");
endmodule
bind vup_uv_pg vup_uv_pg_chk #(.RETRY_WAIT_CYCLES(RETRY_WAIT_CYCLES)) u_vup_uv_pg_chk (.*);

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench import vup_pkg::*;;
  localparam int RW = 20;
  logic clk, resetn, cmd_wr, cmd_rd, write_protect, vin_valid, vout_valid, on_cmd, other_fault, rd_ack_q;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, strap_uv_fault, strap_vout_cmd, vin_meas, vout_meas, vout_uv_limit, rd_data_q, rdv;
  logic output_en_q, power_good_q, alert_line_n_q, stat_none_q, stat_input_q;
  logic stat_vin_uv_warn_q, stat_vin_uv_fault_q, uv_fault_active_q, uv_warn_active_q;
  int bad_count = 0;
  int comparisons = 0;
  logic [7:0] acts [4] = '{8'h80, 8'hC7, 8'hB8, 8'h07};
  // Output enable after fault, after recovery, after clear
  logic [2:0] ens [4] = '{3'b100, 3'b110, 3'b110, 3'b111};
  vup_uv_pg #(.RETRY_WAIT_CYCLES(RW)) u_vup_uv_pg (.*);
  vup_host_model u_vup_host_model (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic samp(input logic sel, input logic [15:0] v);
    tick(1);
    vin_meas = sel ? ~v : v;
    vout_meas = sel ? v : ~v;
    vin_valid = !sel;
    vout_valid = sel;
    tick(1);
    vin_valid = 1'b0;
    vout_valid = 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    u_vup_host_model.rd(c, rdv);
    `CHK("rd_data_q", e, rdv)
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    tick(20000);
    bad_count++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    write_protect = 1'b0;
    vin_valid = 1'b0;
    vout_valid = 1'b0;
    on_cmd = 1'b1;
    other_fault = 1'b0;
    strap_uv_fault = 16'hCA00;
    strap_vout_cmd = 16'h1000;
    vin_meas = 16'hCA58;
    vout_meas = 16'h0000;
    vout_uv_limit = 16'h0C00;
    tick(8);
    resetn = 1'b1;
    tick(2);
    rdchk(CMD_VIN_UV_ACTION, 16'h0080);
    rdchk(CMD_VIN_UV_FAULT, 16'hCA00);
    rdchk(CMD_VIN_UV_WARN, 16'hCA0F);
    rdchk(CMD_PG_ON, 16'h0E68);
    rdchk(8'h5B, 16'h0000);
    write_protect = 1'b1;
    u_vup_host_model.wr(CMD_VIN_UV_FAULT, 16'h1234);
    rdchk(CMD_VIN_UV_FAULT, 16'hCA00);
    write_protect = 1'b0;
    u_vup_host_model.wr(CMD_VIN_UV_WARN, 16'hCA10);
    rdchk(CMD_VIN_UV_WARN, 16'hCA10);
    u_vup_host_model.wr(CMD_PG_ON, 16'h0E00);
    rdchk(CMD_PG_ON, 16'h0E00);
    for (int i = 0; i < 4; i++) begin
      u_vup_host_model.wr(CMD_VIN_UV_ACTION, {8'h00, acts[i]});
      rdchk(CMD_VIN_UV_ACTION, {8'h00, acts[i]});
      samp(0, 16'hC990);
      `CHK("fault", 6'h3E, {stat_none_q, stat_input_q, stat_vin_uv_warn_q, stat_vin_uv_fault_q, uv_fault_active_q, alert_line_n_q})
      tick(1);
      `CHK("en_fault", ens[i][0], output_en_q)
      if (acts[i] == 8'hB8) begin
        // Output stays off for exactly one interval counted from the fault edge
        tick(RW - 2);
        `CHK("en_wait", 1'b0, output_en_q)
        tick(1);
        `CHK("en_retry", 1'b1, output_en_q)
      end
      samp(0, 16'hCA08);
      `CHK("hyst", 1'b1, uv_fault_active_q)
      samp(0, 16'hCA58);
      `CHK("hyst", 1'b0, uv_fault_active_q)
      tick(1);
      `CHK("en_rec", ens[i][1], output_en_q)
      `CHK("sticky", 1'b1, stat_vin_uv_fault_q)
      u_vup_host_model.wr(CMD_CLEAR_FAULTS, 16'h0000);
      tick(2);
      `CHK("clear", 6'h01, {stat_none_q, stat_input_q, stat_vin_uv_warn_q, stat_vin_uv_fault_q, uv_warn_active_q, alert_line_n_q})
      `CHK("en_clr", ens[i][2], output_en_q)
    end
    samp(0, 16'hCA08);
    `CHK("warn", 6'h3A, {stat_none_q, stat_input_q, stat_vin_uv_warn_q, stat_vin_uv_fault_q, uv_warn_active_q, alert_line_n_q})
    samp(0, 16'hCA58);
    u_vup_host_model.wr(CMD_CLEAR_FAULTS, 16'h0000);
    samp(1, 16'h0F00);
    `CHK("pg_on", 1'b1, power_good_q)
    samp(1, 16'h0D00);
    `CHK("pg_hold", 1'b1, power_good_q)
    samp(1, 16'h0B00);
    `CHK("pg_off", 1'b0, power_good_q)
    other_fault = 1'b1;
    tick(2);
    `CHK("en_other", 1'b0, output_en_q)
    other_fault = 1'b0;
    on_cmd = 1'b0;
    tick(2);
    `CHK("en_off", 1'b0, output_en_q)
    on_cmd = 1'b1;
    tick(2);
    `CHK("en_on", 1'b1, output_en_q)
    // Another fault during the retry wait ends the retries
    u_vup_host_model.wr(CMD_VIN_UV_ACTION, 16'h00B8);
    samp(0, 16'hC990);
    other_fault = 1'b1;
    tick(RW + 4);
    other_fault = 1'b0;
    tick(2);
    `CHK("en_stop", 1'b0, output_en_q)
    u_vup_host_model.wr(CMD_CLEAR_FAULTS, 16'h0000);
    tick(2);
    `CHK("en_clr2", 1'b1, output_en_q)
    stop_test();
  end
endmodule
